// *** sqac_pkg.sv ***
package sqac_pkg;
    // register byte offsets (printed offsets are not word aligned: these are indices)
    localparam logic [19:0] IDX_LINK_SYNC_STATE = 20'h30804;
    localparam logic [19:0] IDX_ALIGN_BYPASS    = 20'h30821;
    localparam logic [19:0] IDX_CHAR_CTRL       = 20'h30830;
    localparam logic [19:0] IDX_GROUP_RESYNC    = 20'h30822;
    localparam logic [19:0] IDX_IRQ_STATUS      = 20'h30823;
    localparam logic [19:0] IDX_IRQ_MASK        = 20'h30824;
    localparam int          ADDR_W              = 22;

    // field positions; msb-first bit n of a byte sits at data bit 7-n
    localparam int BIT_RESYNC4   = 1;  // msb-first [6]
    localparam int BIT_XAUI_SEL  = 0;  // msb-first [7]
    localparam int BIT_BYPASS    = 7;  // msb-first [0]
    localparam int POS_RXSEL     = 2;  // msb-first [4:5]
    localparam int POS_TXSEL     = 0;  // msb-first [6:7]
    localparam int BIT_CHAR_ENA  = 3;  // msb-first [4]
    localparam int BIT_CHAR_TX   = 2;  // msb-first [5]
    localparam int POS_CHAR_CHAN = 0;  // msb-first [6:7]

    // bits kept on a write; reserved bits are dropped and read back zero
    localparam logic [7:0] MASK_ALIGN_BYPASS = 8'h8f;
    localparam logic [7:0] MASK_CHAR_CTRL    = 8'h0f;
    localparam logic [7:0] MASK_GROUP_RESYNC = 8'h03;

    // link sync state codes
    localparam logic [1:0] SYNC_NONE    = 2'h0;
    localparam logic [1:0] SYNC_PARTIAL = 2'h1;
    localparam logic [1:0] SYNC_DONE    = 2'h2;

    // interrupt status bits
    localparam int IRQ_RESYNC   = 0;
    localparam int IRQ_SYNCLOST = 1;
    localparam int IRQ_SYNCDONE = 2;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {RS_IDLE, RS_PULSE} sqac_rs_t;
endpackage

// *** sqac_quad_ctrl.sv ***
`timescale 1ns/10ps
module sqac_quad_ctrl #(
    parameter int NCH    = 4,
    parameter int DATA_W = 10
) (
    input  wire logic                           core_clk,
    input  wire logic                           rstn,
    input  wire logic [sqac_pkg::ADDR_W-1:0]    busAddr,
    input  wire logic [7:0]                     busWdata,
    input  wire logic                           busWr,
    input  wire logic                           busRd,
    output logic [7:0]                          busRdata,
    output logic                                irq,
    input  wire logic [1:0]                     testModeInputs,
    input  wire logic                           coreEnablePinN,
    input  wire logic [NCH-1:0]                 perChannelLinkFsmEnable,
    input  wire logic [2*NCH-1:0]               linkSyncStateIn,
    output logic [NCH-1:0]                      linkFsmXaui,
    output logic [NCH-1:0]                      linkFsmEnable,
    output logic [NCH-1:0]                      alignFifoPtrReset,
    output logic                                alignFifoBypass,
    input  wire logic [NCH-1:0]                 chanRxByteClk,
    input  wire logic [NCH-1:0]                 chanTxByteClk,
    output logic                                sharedRxByteClock,
    output logic                                sharedTxByteClock,
    output logic                                charModeActive,
    input  wire logic [NCH-1:0]                 chanRxTbc,
    input  wire logic [NCH-1:0]                 chanCodeViol,
    input  wire logic [NCH-1:0]                 chanByteSync,
    input  wire logic [NCH-1:0]                 chanWordSync,
    input  wire logic [NCH-1:0]                 chanRecClk0,
    input  wire logic [NCH-1:0]                 chanRecClk1,
    input  wire logic [NCH*DATA_W-1:0]          chanRxData,
    output logic [DATA_W+5:0]                   hostDataPinsOut,
    output logic                                hostDataPinsOe,
    input  wire logic [DATA_W:0]                hostAddressPins,
    output logic [NCH-1:0]                      charTxOverride,
    output logic                                charTxClk,
    output logic [DATA_W-1:0]                   charTxData
);
    typedef sqac_pkg::sqac_rs_t sqac_rs_st_t;

    logic [7:0]   bypassClkReg_r;
    logic [7:0]   charCtrl_r;
    logic [7:0]   groupResync_r;
    logic [2:0]   irqStatus_r;
    logic [2:0]   irqMask_r;
    logic [7:0]   syncStatus_r;
    logic [7:0]   syncPrev_r;
    logic         resyncPrev_r;
    sqac_rs_st_t  rsState_r;
    logic [1:0]   rxSel;
    logic [1:0]   txSel;
    logic [1:0]   charChan;
    logic         resyncEdge;
    logic [2:0]   irqEvents;
    logic         writeSelf;
    logic [7:0]   rdMux;
    logic [DATA_W+5:0] charObs_r;
    logic [DATA_W:0]   hostAddr_r;
    logic [DATA_W:0]   hostAddrS1_r;
    logic [DATA_W:0]   hostAddrS2_r;
    logic [DATA_W:0]   hostAddrS3_r;
    logic [DATA_W:0]   hostAddrAgree;
    logic [NCH-1:0]    chanLostSync;
    logic [NCH-1:0]    chanGotSync;

    assign rxSel    = bypassClkReg_r[sqac_pkg::POS_RXSEL +: 2];
    assign txSel    = bypassClkReg_r[sqac_pkg::POS_TXSEL +: 2];
    assign charChan = charCtrl_r[sqac_pkg::POS_CHAR_CHAN +: 2];
    assign writeSelf = busWr && (busAddr == {sqac_pkg::IDX_GROUP_RESYNC, 2'b00});

    // bypass and byte clock sources; reserved bits are not stored
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bypassClkReg_r <= sqac_pkg::RESET_BYTE;
        end else if (busWr && busAddr == {sqac_pkg::IDX_ALIGN_BYPASS, 2'b00}) begin
            bypassClkReg_r <= busWdata & sqac_pkg::MASK_ALIGN_BYPASS;
        end
    end

    // characterization control byte
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            charCtrl_r <= sqac_pkg::RESET_BYTE;
        end else if (busWr && busAddr == {sqac_pkg::IDX_CHAR_CTRL, 2'b00}) begin
            charCtrl_r <= busWdata & sqac_pkg::MASK_CHAR_CTRL;
        end
    end

    // group resync and link select byte
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            groupResync_r <= sqac_pkg::RESET_BYTE;
        end else if (writeSelf) begin
            groupResync_r <= busWdata & sqac_pkg::MASK_GROUP_RESYNC;
        end
    end

    // interrupt mask, same layout as the status bits
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irqMask_r <= 3'h0;
        end else if (busWr && busAddr == {sqac_pkg::IDX_IRQ_MASK, 2'b00}) begin
            irqMask_r <= busWdata[2:0];
        end
    end

    assign resyncEdge = groupResync_r[sqac_pkg::BIT_RESYNC4] && !resyncPrev_r;

    // group resync sequencer, one pulse per rising edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            resyncPrev_r <= 1'b0;
            rsState_r    <= sqac_pkg::RS_IDLE;
        end else begin
            resyncPrev_r <= groupResync_r[sqac_pkg::BIT_RESYNC4];
            case (rsState_r)
                sqac_pkg::RS_IDLE: begin
                    rsState_r <= resyncEdge ? sqac_pkg::RS_PULSE : sqac_pkg::RS_IDLE;
                end
                sqac_pkg::RS_PULSE: begin
                    rsState_r <= sqac_pkg::RS_IDLE;
                end
                default: begin
                    rsState_r <= sqac_pkg::RS_IDLE;
                end
            endcase
        end
    end

    // pointer reset to all four fifos together
    assign alignFifoPtrReset = {NCH{rsState_r == sqac_pkg::RS_PULSE}};

    assign linkFsmXaui   = {NCH{groupResync_r[sqac_pkg::BIT_XAUI_SEL]}};
    assign linkFsmEnable = groupResync_r[sqac_pkg::BIT_XAUI_SEL] ? {NCH{1'b1}}
                                                                   : perChannelLinkFsmEnable;

    assign alignFifoBypass = bypassClkReg_r[sqac_pkg::BIT_BYPASS];

    // rx source; the field is bit-reversed so 10 means B
    assign sharedRxByteClock = chanRxByteClk[{rxSel[0], rxSel[1]}];
    assign sharedTxByteClock = chanTxByteClk[{txSel[0], txSel[1]}];

    // mode needs the bit plus qualifying pins
    // outside logic holds test inputs at 00 and core enable low
    assign charModeActive = charCtrl_r[sqac_pkg::BIT_CHAR_ENA]
                            && (testModeInputs == 2'b00) && !coreEnablePinN;

    // observed signals registered onto host data pins
    // channel chosen by char channel field (plain binary)
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            charObs_r <= '0;
        end else begin
            charObs_r <= {chanRxTbc[charChan], chanCodeViol[charChan], chanByteSync[charChan],
                          chanWordSync[charChan], chanRecClk0[charChan], chanRecClk1[charChan],
                          chanRxData[charChan*DATA_W +: DATA_W]};
        end
    end
    assign hostDataPinsOut = charObs_r;
    assign hostDataPinsOe  = charModeActive;

    // host address pins come from outside the clock domain: three stages
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hostAddrS1_r <= '0;
            hostAddrS2_r <= '0;
            hostAddrS3_r <= '0;
        end else begin
            hostAddrS1_r <= hostAddressPins;
            hostAddrS2_r <= hostAddrS1_r;
            hostAddrS3_r <= hostAddrS2_r;
        end
    end

    // a bit moves on only once the last two stages agree, so a pin caught
    // mid-change is never passed on; costs a few cycles of latency
    assign hostAddrAgree = ~(hostAddrS2_r ^ hostAddrS3_r);

    // host address pins feed tx of the chosen channel
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hostAddr_r <= '0;
        end else begin
            hostAddr_r <= (hostAddr_r & ~hostAddrAgree) | (hostAddrS3_r & hostAddrAgree);
        end
    end
    assign charTxClk  = hostAddr_r[DATA_W];
    assign charTxData = hostAddr_r[DATA_W-1:0];

    // only the selected channel takes its tx inputs from the host pins
    for (genvar ch = 0; ch < NCH; ch++) begin : g_txOverride
        assign charTxOverride[ch] = charModeActive && charCtrl_r[sqac_pkg::BIT_CHAR_TX]
                                    && (int'(charChan) == ch);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncStatus_r <= sqac_pkg::RESET_BYTE;
            syncPrev_r   <= sqac_pkg::RESET_BYTE;
        end else begin
            syncStatus_r <= linkSyncStateIn[7:0];
            syncPrev_r   <= syncStatus_r;
        end
    end

    // per-channel moves into and out of the finished sync code
    for (genvar ch = 0; ch < NCH; ch++) begin : g_syncEvt
        assign chanLostSync[ch] = (syncPrev_r[2*ch +: 2] == sqac_pkg::SYNC_DONE)
                                  && (syncStatus_r[2*ch +: 2] != sqac_pkg::SYNC_DONE);
        assign chanGotSync[ch]  = (syncPrev_r[2*ch +: 2] != sqac_pkg::SYNC_DONE)
                                  && (syncStatus_r[2*ch +: 2] == sqac_pkg::SYNC_DONE);
    end

    // events: resync issued, some channel lost sync done, some channel reached sync done
    always_comb begin
        irqEvents = '0;
        irqEvents[sqac_pkg::IRQ_RESYNC]   = resyncEdge;
        irqEvents[sqac_pkg::IRQ_SYNCLOST] = |chanLostSync;
        irqEvents[sqac_pkg::IRQ_SYNCDONE] = |chanGotSync;
    end

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irqStatus_r <= 3'h0;
        end else begin
            if (busWr && busAddr == {sqac_pkg::IDX_IRQ_STATUS, 2'b00})
                irqStatus_r <= (irqStatus_r & ~busWdata[2:0]) | irqEvents;
            else
                irqStatus_r <= irqStatus_r | irqEvents;
        end
    end
    assign irq = |(irqStatus_r & irqMask_r);

    // read mux; unmapped addresses read zero
    always_comb begin
        case (busAddr)
            {sqac_pkg::IDX_LINK_SYNC_STATE, 2'b00}: rdMux = syncStatus_r;
            {sqac_pkg::IDX_ALIGN_BYPASS, 2'b00}:    rdMux = bypassClkReg_r;
            {sqac_pkg::IDX_CHAR_CTRL, 2'b00}:       rdMux = charCtrl_r;
            {sqac_pkg::IDX_GROUP_RESYNC, 2'b00}:    rdMux = groupResync_r;
            {sqac_pkg::IDX_IRQ_STATUS, 2'b00}:      rdMux = {5'h00, irqStatus_r};
            {sqac_pkg::IDX_IRQ_MASK, 2'b00}:        rdMux = {5'h00, irqMask_r};
            default:                                rdMux = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busRdata <= 8'h00;
        end else begin
            busRdata <= busRd ? rdMux : 8'h00;
        end
    end
endmodule

// *** sqac_link_partner.sv ***
`timescale 1ns/10ps
module sqac_link_partner (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  syncCode,
    output logic [7:0]       linkSyncState,
    output logic [79:0]      lane_r
);
    // far side reports whatever sync state the bench asks of it
    assign linkSyncState = syncCode;
    // the lane word steps each cycle; only lane bit 0 toggles every cycle, and bit k repeats every 2^(k+1) cycles
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) lane_r <= 80'h0;
        else lane_r <= lane_r * 80'h5851f42d4c957f2d + 80'h3c6ef372fe94f82b;
    end
endmodule

// *** sqac_quad_ctrl_chk.sv ***
`timescale 1ns/10ps
module sqac_quad_ctrl_chk #(parameter int NCH = 4) (
    input wire logic            core_clk,
    input wire logic            rstn,
    input wire logic [21:0]     busAddr,
    input wire logic [7:0]      busWdata,
    input wire logic            busWr,
    input wire logic [1:0]      testModeInputs,
    input wire logic            coreEnablePinN,
    input wire logic [NCH-1:0]  perChannelLinkFsmEnable,
    input wire logic [NCH-1:0]  linkFsmXaui,
    input wire logic [NCH-1:0]  linkFsmEnable,
    input wire logic [NCH-1:0]  alignFifoPtrReset,
    input wire logic            alignFifoBypass,
    input wire logic [NCH-1:0]  chanRxByteClk,
    input wire logic [NCH-1:0]  chanTxByteClk,
    input wire logic            sharedRxByteClock,
    input wire logic            sharedTxByteClock,
    input wire logic            hostDataPinsOe
);
    logic [7:0] grp_r, byp_r, chr_r;
    logic       riseWr, charQual;
    // shadow copies of the control bytes as software writes them
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) {grp_r, byp_r, chr_r} <= 24'h0;
        else if (busWr && busAddr == 22'hc2088) grp_r <= busWdata;
        else if (busWr && busAddr == 22'hc2084) byp_r <= busWdata;
        else if (busWr && busAddr == 22'hc20c0) chr_r <= busWdata;
    end
    // only a 0-to-1 write may start a resync; holding the bit high must not
    assign riseWr = busWr && busAddr == 22'hc2088 && busWdata[1] && !grp_r[1];
    assign charQual = chr_r[3] && testModeInputs == 2'h0 && !coreEnablePinN;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence ptrPulse;
        alignFifoPtrReset == 4'hf ##1 alignFifoPtrReset == 4'h0;
    endsequence
    resync_pulse_a: assert property (riseWr |-> ##2 ptrPulse)
        else $error("group resync pulse missing");
    resync_cause_a: assert property ($rose(|alignFifoPtrReset) |-> $past(riseWr, 2))
        else $error("resync pulse without rising write");
    xaui_link_select_a: assert property (linkFsmXaui == {NCH{grp_r[0]}} && linkFsmEnable ==
        (grp_r[0] ? 4'hf : perChannelLinkFsmEnable)) else $error("link fsm select wrong");
    fifo_bypass_a: assert property (alignFifoBypass == byp_r[7])
        else $error("bypass level wrong");
    rx_clk_sel_a: assert property (sharedRxByteClock == chanRxByteClk[{byp_r[2], byp_r[3]}])
        else $error("rx byte clock source wrong");
    tx_clk_sel_a: assert property (sharedTxByteClock == chanTxByteClk[{byp_r[0], byp_r[1]}])
        else $error("tx byte clock source wrong");
    char_on_a: assert property (charQual [*2] |-> hostDataPinsOe)
        else $error("char mode not entered");
    char_off_a: assert property ((!charQual) [*2] |-> !hostDataPinsOe)
        else $error("char mode without qualifiers");
endmodule
bind sqac_quad_ctrl sqac_quad_ctrl_chk #(.NCH(NCH)) u_chk (.core_clk(core_clk), .rstn(rstn),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .testModeInputs(testModeInputs),
    .coreEnablePinN(coreEnablePinN), .perChannelLinkFsmEnable(perChannelLinkFsmEnable),
    .linkFsmXaui(linkFsmXaui), .linkFsmEnable(linkFsmEnable), .alignFifoBypass(alignFifoBypass),
    .alignFifoPtrReset(alignFifoPtrReset), .chanRxByteClk(chanRxByteClk),
    .chanTxByteClk(chanTxByteClk), .sharedRxByteClock(sharedRxByteClock),
    .sharedTxByteClock(sharedTxByteClock), .hostDataPinsOe(hostDataPinsOe));

// *** sqac_quad_ctrl_bench.sv ***
`timescale 1ns/10ps
module sqac_quad_ctrl_bench;
    logic        core_clk = 1'b0, rstn = 1'b0, busWr = 1'b0, busRd = 1'b0, coreEnablePinN = 1'b0;
    logic [21:0] busAddr = 22'h0;
    logic [7:0]  busWdata = 8'h0, syncCode = 8'h0, busRdata, linkSyncStateIn;
    logic [1:0]  testModeInputs = 2'h0;
    logic [3:0]  perChannelLinkFsmEnable = 4'h5, linkFsmXaui, linkFsmEnable;
    logic [3:0]  alignFifoPtrReset, charTxOverride;
    logic        irq, alignFifoBypass, sharedRxByteClock, sharedTxByteClock, charModeActive;
    logic        hostDataPinsOe, charTxClk;
    logic [15:0] hostDataPinsOut, expOut;
    logic [10:0] hostAddressPins = 11'h5a3;
    logic [9:0]  charTxData;
    logic [79:0] lane;
    int          errorCnt = 0, compares = 0;
    sqac_quad_ctrl u_sqac_quad_ctrl (.core_clk, .rstn, .busAddr, .busWdata, .busWr, .busRd,
        .busRdata, .irq, .testModeInputs, .coreEnablePinN, .perChannelLinkFsmEnable,
        .linkSyncStateIn, .linkFsmXaui, .linkFsmEnable, .alignFifoPtrReset, .alignFifoBypass,
        .chanRxByteClk(lane[3:0]), .chanTxByteClk(lane[7:4]), .sharedRxByteClock,
        .sharedTxByteClock, .charModeActive, .chanRxTbc(lane[11:8]), .chanCodeViol(lane[15:12]),
        .chanByteSync(lane[19:16]), .chanWordSync(lane[23:20]), .chanRecClk0(lane[27:24]),
        .chanRecClk1(lane[31:28]), .chanRxData(lane[71:32]), .hostDataPinsOut, .hostDataPinsOe,
        .hostAddressPins, .charTxOverride, .charTxClk, .charTxData);
    sqac_link_partner u_sqac_link_partner (.core_clk, .rstn, .syncCode,
        .linkSyncState(linkSyncStateIn), .lane_r(lane));
    // clock and verdict
    initial forever #4 core_clk = ~core_clk;
    task automatic giveVerdict;
        $display("compares %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // bus tasks start at an edge; a write returns at its sampling edge
    task automatic wr(input logic [19:0] idx, input logic [7:0] d);
        busAddr <= {idx, 2'h0};
        busWdata <= d;
        busWr <= 1'b1;
        at(1);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] idx, input logic [7:0] exp, input string nm);
        busAddr <= {idx, 2'h0};
        busRd <= 1'b1;
        at(1);
        busRd <= 1'b0;
        #1 chk(nm, busRdata, exp);
        at(1);
    endtask
    task automatic testReset;
        rd(20'h30822, 8'h00, "grpReset");
        rd(20'h30821, 8'h00, "bypReset");
        rd(20'h30804, 8'h00, "syncReset");
        rd(20'h30825, 8'h00, "unmapped");
    endtask
    task automatic testResync;
        wr(20'h30822, 8'h02);
        at(1);
        #1 chk("ptrOn", alignFifoPtrReset, 4'hf);
        chk("irqMasked", irq, 1'b0);
        at(1);
        #1 chk("ptrOff", alignFifoPtrReset, 4'h0);
        at(1);
        wr(20'h30822, 8'h02);
        at(1);
        #1 chk("ptrHeld", alignFifoPtrReset, 4'h0);
        at(1);
        wr(20'h30824, 8'h01);
        #1 chk("irqOn", irq, 1'b1);
        at(1);
        rd(20'h30823, 8'h01, "irqStat");
        wr(20'h30823, 8'h01);
        #1 chk("irqOff", irq, 1'b0);
        at(1);
    endtask
    task automatic testXaui;
        wr(20'h30822, 8'h01);
        #1 chk("xauiOn", linkFsmXaui, 4'hf);
        chk("enOverride", linkFsmEnable, 4'hf);
        at(1);
        wr(20'h30822, 8'h00);
        #1 chk("enFollow", linkFsmEnable, 4'h5);
        at(1);
    endtask
    // rx source walks A..D while tx walks D..A; reserved bits are written as ones
    task automatic testClkSel;
        for (int s = 0; s < 4; s++) begin
            wr(20'h30821, {s[0], 3'h7, s[0], s[1], ~s[0], ~s[1]});
            rd(20'h30821, {s[0], 3'h0, s[0], s[1], ~s[0], ~s[1]}, "bypRead");
            repeat (8) begin
                #1 chk("rxClk", sharedRxByteClock, lane[s]);
                chk("txClk", sharedTxByteClock, lane[7-s]);
                chk("bypass", alignFifoBypass, s[0]);
                at(1);
            end
        end
    endtask
    task automatic testChar;
        for (int c = 0; c < 4; c++) begin
            hostAddressPins <= 11'h5a3 ^ {c[2:0], 8'h00};
            at(4);
            wr(20'h30830, {4'h0, 2'h3, c[1:0]});
            at(1);
            #1 expOut = {lane[8+c], lane[12+c], lane[16+c], lane[20+c], lane[24+c],
                lane[28+c], lane[32+10*c +: 10]};
            at(1);
            #1 chk("hostData", hostDataPinsOut, expOut);
            chk("hostOe", hostDataPinsOe, 1'b1);
            chk("txOverride", charTxOverride, 4'h1 << c);
            chk("txData", {charTxClk, charTxData}, hostAddressPins);
            chk("charMode", charModeActive, 1'b1);
            at(1);
        end
        testModeInputs <= 2'h1;
        at(2);
        #1 chk("oeTestMode", hostDataPinsOe, 1'b0);
        chk("modeTestIn", charModeActive, 1'b0);
        at(1);
        testModeInputs <= 2'h0;
        coreEnablePinN <= 1'b1;
        at(2);
        #1 chk("oeCorePin", hostDataPinsOe, 1'b0);
        at(1);
    endtask
    task automatic testSync;
        syncCode <= 8'h86;
        at(2);
        rd(20'h30804, 8'h86, "syncStat");
        rd(20'h30823, 8'h04, "irqSync");
        syncCode <= 8'h06;
        at(2);
        rd(20'h30804, 8'h06, "syncLost");
        rd(20'h30823, 8'h06, "irqLost");
    endtask
    // whole run is about 130 cycles, so over twenty times that means a hang
    initial begin
        at(3000);
        errorCnt++;
        giveVerdict;
    end
    initial begin
        at(4);
        rstn <= 1'b1;
        testReset;
        testResync;
        testXaui;
        testClkSel;
        testChar;
        testSync;
        giveVerdict;
    end
endmodule
